/* common/vtm_pkg.sv */
package vtm_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register port geometry.
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	// Register offsets on the register port.
	localparam logic [ADDR_W-1:0] OFF_CTRL_STATUS = 8'h0E;
	localparam logic [ADDR_W-1:0] OFF_LEAD_LOW    = 8'h0F;
	localparam logic [ADDR_W-1:0] OFF_TRAIL_LOW   = 8'h10;

	////////////////////////////////////////////////////////////////////////////
	// Control/status field positions.
	localparam int BIT_START      = 0;
	localparam int BIT_AXIS       = 1;
	localparam int LEAD_HIGH_LSB  = 2;
	localparam int TRAIL_HIGH_LSB = 5;
	localparam int HIGH_W         = 3;

	// Reset values.
	localparam logic [DATA_W-1:0] RST_CTRL_STATUS = 8'hFC;
	localparam logic [DATA_W-1:0] RST_LOW         = 8'hFF;
	localparam logic [HIGH_W-1:0] RST_HIGH        = 3'h7;
	localparam logic [DATA_W-1:0] READ_UNMAPPED   = 8'h00;

	////////////////////////////////////////////////////////////////////////////
	// Measurement counter and special result values.
	localparam int               CNT_W          = 11;
	localparam logic [CNT_W-1:0] CNT_MAX        = 11'h7FF;
	localparam logic [CNT_W-1:0] CNT_ZERO       = 11'h000;
	localparam logic [CNT_W-1:0] CNT_ONE        = 11'h001;
	localparam logic [CNT_W-1:0] LEAD_NEG_VAL   = 11'h001;
	localparam logic [CNT_W-1:0] TRAIL_NEG_VAL  = 11'h000;

	// Frames spanned by one measurement, per axis.
	localparam logic [1:0] FRAMES_HORIZ = 2'h1;
	localparam logic [1:0] FRAMES_VERT  = 2'h2;

	// Oscillator clock rate of this build, in MHz.
	localparam int OSC_MHZ = 25;

	typedef enum logic [1:0] {
		PH_IDLE = 2'b00,
		PH_ARM  = 2'b01,
		PH_RUN  = 2'b10
	} vtm_phase_e;

endpackage

/* design/vtm_timing_measure_unit.sv */
// The strobed register port is this design's own decision.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// R01: One 11-bit counter does every measurement; all results are 11 bits.
// R02: Axis bit 1 selects horizontal measurement, 0 selects vertical.
// R03: Horizontal lead: minimum clocks from hsync fall to first video rise.
// R04: Horizontal trail: minimum clocks from last video fall to hsync rise.
// R05: Horizontal counting is suspended while vertical sync is high.
// R06: Vertical lead: minimum hsync pulses from vsync fall to first video rise.
// R07: Vertical trail: minimum hsync pulses from last video fall to vsync rise.
// R08: Software sets start; hardware clears it at completion; zero writes ignored.
// R09: Axis bit cannot change while start is one.
// R10: Results move to result registers at the end; valid once start clears.
// R11: Horizontal: wait next vsync pulse, track until following vsync rise, clear start.
// R12: Vertical: track minima over two consecutive frames, then clear start.
// R13: Counter overflow reports the affected result as 7FFh.
// R14: Video never high during measurement reports the result as 7FFh.
// R15: Video already high at sync fall reports the lead result as 1.
// R16: Video still high at sync rise reports a distinctive trail value.
// R17: Lead low byte to lead register, upper three bits to status bits 4:2.
// R18: Trail low byte to trail register, upper three bits to status bits 7:5.
// R19: Result registers hold horizontal minima when axis is 1, vertical when 0.
// R20: Reset: control/status reads FCh, both low result registers read FFh.
// R21: Status bits 7:2 are read-only results; bits 1:0 are software writable.
// R22: Horizontal measurements count the oscillator clock.
// R23: Sync inputs are treated as positive-going pulses.
// R24: Minimum trackers preset to all ones when a measurement starts.
// R25: Counter saturates at its maximum rather than wrapping.
module vtm_timing_measure_unit (
	input  wire logic                        clk,
	input  wire logic                        rst_n,
	input  wire logic [vtm_pkg::ADDR_W-1:0]  regAddr,
	input  wire logic [vtm_pkg::DATA_W-1:0]  regWrData,
	input  wire logic                        regWr,
	input  wire logic                        regRd,
	output logic      [vtm_pkg::DATA_W-1:0]  regRdData,
	input  wire logic                        hsyncOut,
	input  wire logic                        vsyncOut,
	input  wire logic                        activeVideoIn,
	output logic                             measureBusy
);
	import vtm_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Input synchronisers. Bit 0 horizontal sync, bit 1 vertical sync,
	// bit 2 active video. The first stage feeds only the second stage.
	// Every edge acts three clocks after its pin moves. Both ends of an
	// interval share that delay, so measured lengths are unaffected.
	logic [2:0]       pinMeta_q;
	logic [2:0]       pinStab_q;
	logic [2:0]       pinPrev_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pinMeta_q <= 3'h0;
			pinStab_q <= 3'h0;
			pinPrev_q <= 3'h0;
		end else begin
			pinMeta_q <= {activeVideoIn, vsyncOut, hsyncOut};
			pinStab_q <= pinMeta_q;
			pinPrev_q <= pinStab_q;
		end
	end

	logic             hRise;
	logic             hFall;
	logic             vRise;
	logic             vFall;
	logic             vHigh;
	logic             avHigh;
	logic             avRise;
	logic             avFall;

	// Both syncs are positive pulses: rise opens the pulse, fall closes it. [R23]
	assign hRise  = pinStab_q[0] & ~pinPrev_q[0];
	assign hFall  = ~pinStab_q[0] & pinPrev_q[0];
	assign vRise  = pinStab_q[1] & ~pinPrev_q[1];
	assign vFall  = ~pinStab_q[1] & pinPrev_q[1];
	assign vHigh  = pinStab_q[1];
	assign avHigh = pinStab_q[2];
	assign avRise = pinStab_q[2] & ~pinPrev_q[2];
	assign avFall = ~pinStab_q[2] & pinPrev_q[2];

	////////////////////////////////////////////////////////////////////////////
	// Software controls.
	logic             start_q;
	logic             axisHoriz_q;
	logic             ctrlWr;
	logic             measDone;

	assign ctrlWr = regWr && (regAddr == OFF_CTRL_STATUS);

	// Completion can only happen while start is one, and a write of one then
	// changes nothing, so when a set and a clear meet in the same cycle the clear wins.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			start_q <= 1'b0;
		end else if (measDone) begin
			start_q <= 1'b0; // [R08]
		end else if (ctrlWr && regWrData[BIT_START]) begin
			start_q <= 1'b1; // [R08]
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			axisHoriz_q <= 1'b0;
		end else if (ctrlWr && !start_q) begin
			axisHoriz_q <= regWrData[BIT_AXIS]; // [R09] [R21]
		end
	end

	// Busy rises one clock after start so that the pin comes straight from a
	// flip-flop; it drops on the completion edge itself, in step with start.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			measureBusy <= 1'b0;
		end else begin
			measureBusy <= start_q && !measDone;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Measurement sequencing.
	vtm_phase_e       phase_q;
	logic [1:0]       frameCnt_q;
	logic [1:0]       frameTarget;
	logic             active;

	// The frame counter stops one short of the target, because the closing
	// vsync rise itself ends the last frame.
	assign frameTarget = axisHoriz_q ? FRAMES_HORIZ : FRAMES_VERT; // [R11] [R12]

	// The vsync fall that leaves the arm phase is already the first frame's
	// sync fall in vertical mode, so it is measured too.
	assign active = (phase_q == PH_RUN || (phase_q == PH_ARM && vFall))
	                && !(axisHoriz_q && vHigh); // [R05]

	assign measDone = (phase_q == PH_RUN) && vRise
	                  && (frameCnt_q == frameTarget - 2'h1); // [R11] [R12]

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_q    <= PH_IDLE;
			frameCnt_q <= 2'h0;
		end else begin
			unique case (phase_q)
				PH_IDLE: begin
					if (start_q) begin
						phase_q <= PH_ARM;
					end
				end
				PH_ARM: begin
					frameCnt_q <= 2'h0;
					if (vFall) begin
						phase_q <= PH_RUN; // [R11]
					end
				end
				PH_RUN: begin
					if (measDone) begin
						phase_q <= PH_IDLE;
					end else if (vRise) begin
						frameCnt_q <= frameCnt_q + 2'h1; // [R12]
					end
				end
				default: begin
					phase_q <= PH_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Shared interval counter. Lead and trail intervals never overlap within a
	// line or frame, so one counter serves both.
	logic             syncRise;
	logic             syncFall;
	logic             tick;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;

	assign syncRise = axisHoriz_q ? hRise : vRise; // [R02]
	assign syncFall = axisHoriz_q ? hFall : vFall; // [R02]
	// Horizontal counts oscillator clocks, vertical counts hsync pulses.
	assign tick     = axisHoriz_q ? 1'b1 : hRise; // [R22] [R06] [R07]

	// A restart wins over a step, so an interval that opens in this cycle
	// already counts the tick that comes with it.
	always_comb begin
		cnt_d = cnt_q;
		if (active && (syncFall || avFall)) begin
			cnt_d = tick ? CNT_ONE : CNT_ZERO; // [R01]
		end else if (active && tick && cnt_q != CNT_MAX) begin
			// Saturating keeps an overflowed interval from posing as a small minimum.
			cnt_d = cnt_q + CNT_ONE; // [R25] [R13]
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= CNT_ZERO;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Interval endpoints.
	logic             leadWait_q;
	logic             trailArm_q;
	logic             leadCandOk;
	logic [CNT_W-1:0] leadCand;
	logic             trailCandOk;
	logic [CNT_W-1:0] trailCand;

	always_comb begin
		leadCandOk = 1'b0;
		leadCand   = CNT_MAX;
		if (active && syncFall && avHigh) begin
			leadCandOk = 1'b1;
			leadCand   = LEAD_NEG_VAL; // [R15]
		end else if (active && avRise && leadWait_q) begin
			leadCandOk = 1'b1;
			leadCand   = cnt_q; // [R03] [R06]
		end
	end

	always_comb begin
		trailCandOk = 1'b0;
		trailCand   = CNT_MAX;
		if (active && syncRise && avHigh) begin
			trailCandOk = 1'b1;
			trailCand   = TRAIL_NEG_VAL; // [R16]
		end else if (active && syncRise && trailArm_q) begin
			trailCandOk = 1'b1;
			trailCand   = cnt_q; // [R04] [R07]
		end
	end

	// While video stays low no candidate is ever offered, so the preset
	// maximum survives to the result.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			leadWait_q <= 1'b0;
		end else if (phase_q != PH_RUN && !active) begin
			leadWait_q <= 1'b0;
		end else if (active && syncFall) begin
			leadWait_q <= !avHigh; // [R14]
		end else if (active && avRise) begin
			leadWait_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			trailArm_q <= 1'b0;
		end else if (phase_q != PH_RUN && !active) begin
			trailArm_q <= 1'b0;
		end else if (active && syncRise) begin
			trailArm_q <= 1'b0;
		end else if (active && avFall) begin
			trailArm_q <= 1'b1; // [R14]
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Minimum trackers.
	logic [CNT_W-1:0] leadMin_q;
	logic [CNT_W-1:0] trailMin_q;
	logic [CNT_W-1:0] leadMinNext;
	logic [CNT_W-1:0] trailMinNext;

	assign leadMinNext  = (leadCandOk && leadCand < leadMin_q) ? leadCand : leadMin_q;
	assign trailMinNext = (trailCandOk && trailCand < trailMin_q) ? trailCand : trailMin_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			leadMin_q  <= CNT_MAX;
			trailMin_q <= CNT_MAX;
		end else if (phase_q == PH_IDLE) begin
			leadMin_q  <= CNT_MAX; // [R24]
			trailMin_q <= CNT_MAX; // [R24]
		end else begin
			leadMin_q  <= leadMinNext;
			trailMin_q <= trailMinNext;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Result registers. They change only at completion, so software reading
	// them while start is one still sees the previous measurement.
	logic [DATA_W-1:0] leadLow_q;
	logic [DATA_W-1:0] trailLow_q;
	logic [HIGH_W-1:0] leadHigh_q;
	logic [HIGH_W-1:0] trailHigh_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			leadLow_q   <= RST_LOW; // [R20]
			leadHigh_q  <= RST_HIGH; // [R20]
		end else if (measDone) begin
			leadLow_q   <= leadMinNext[DATA_W-1:0]; // [R10] [R17] [R19]
			leadHigh_q  <= leadMinNext[CNT_W-1:DATA_W]; // [R17]
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			trailLow_q  <= RST_LOW; // [R20]
			trailHigh_q <= RST_HIGH; // [R20]
		end else if (measDone) begin
			trailLow_q  <= trailMinNext[DATA_W-1:0]; // [R10] [R18] [R19]
			trailHigh_q <= trailMinNext[CNT_W-1:DATA_W]; // [R18]
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register reads, answered in the cycle after the strobe.
	logic [DATA_W-1:0] ctrlStatus;

	always_comb begin
		ctrlStatus                                      = RST_CTRL_STATUS;
		ctrlStatus[TRAIL_HIGH_LSB +: HIGH_W]            = trailHigh_q; // [R21]
		ctrlStatus[LEAD_HIGH_LSB +: HIGH_W]             = leadHigh_q; // [R21]
		ctrlStatus[BIT_AXIS]                            = axisHoriz_q;
		ctrlStatus[BIT_START]                           = start_q;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			regRdData <= READ_UNMAPPED;
		end else if (regRd) begin
			case (regAddr)
				OFF_CTRL_STATUS: regRdData <= ctrlStatus;
				OFF_LEAD_LOW:    regRdData <= leadLow_q;
				OFF_TRAIL_LOW:   regRdData <= trailLow_q;
				default:         regRdData <= READ_UNMAPPED;
			endcase
		end
	end

endmodule

/* sim/vtm_checker_sva.sv */
`timescale 1ns/1ps
module vtm_checker (
	input wire logic                       clk,
	input wire logic                       rst_n,
	input wire logic [vtm_pkg::ADDR_W-1:0] regAddr,
	input wire logic [vtm_pkg::DATA_W-1:0] regWrData,
	input wire logic                       regWr,
	input wire logic                       regRd,
	input wire logic [vtm_pkg::DATA_W-1:0] regRdData,
	input wire logic                       hsyncOut,
	input wire logic                       vsyncOut,
	input wire logic                       activeVideoIn,
	input wire logic                       measureBusy
);
	import vtm_pkg::*;
	logic armed_q;
	wire  isCsr   = regAddr == OFF_CTRL_STATUS;
	wire  isLow   = regAddr == OFF_LEAD_LOW || regAddr == OFF_TRAIL_LOW;
	wire  startWr = regWr && isCsr && regWrData[BIT_START];
	// Reset values are only promised until the first launch.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			armed_q <= 1'b0;
		end else if (startWr) begin
			armed_q <= 1'b1;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////////////////
	AST_UNMAPPED_RD: assert property (regRd && !isCsr && !isLow |=> regRdData == READ_UNMAPPED)
		else $error("Unmapped read returned data");
	AST_RESET_LOW: assert property (regRd && isLow && !armed_q |=> regRdData == RST_LOW)
		else $error("Result low byte not at reset value");
	AST_RESET_CSR: assert property (regRd && isCsr && !armed_q |=> regRdData[7:2] == 6'h3F && !regRdData[0])
		else $error("Status not at reset value");
	AST_START_BUSY: assert property (startWr && !measureBusy |-> ##2 measureBusy)
		else $error("Start write did not launch");
	AST_BUSY_CAUSE: assert property ($rose(measureBusy) |-> $past(startWr, 2))
		else $error("Measurement began without a start write");
	AST_START_HELD: assert property (regRd && isCsr && measureBusy ##1 measureBusy |-> regRdData[BIT_START])
		else $error("Start bit low during measurement");
	AST_DONE_VSYNC: assert property ($fell(measureBusy) && $past(rst_n) |-> vsyncOut && $past(vsyncOut, 3))
		else $error("Measurement ended away from a vsync rise");
	AST_IDLE_DONE: assert property (regRd && isCsr && !measureBusy && !$past(measureBusy) && !$past(regWr)
		|=> !regRdData[BIT_START])
		else $error("Start bit set while idle");
endmodule
bind vtm_timing_measure_unit vtm_checker vtm_checker_inst (
	.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
	.regRd(regRd), .regRdData(regRdData), .hsyncOut(hsyncOut), .vsyncOut(vsyncOut),
	.activeVideoIn(activeVideoIn), .measureBusy(measureBusy)
);

/* sim/vtm_video_source.sv */
`timescale 1ns/1ps
module vtm_video_source (
	input  wire logic               clk,
	input  wire logic               run,
	input  wire logic signed [12:0] lead,
	input  wire logic        [12:0] trail,
	input  wire logic        [3:0]  topLines,
	input  wire logic        [3:0]  botLines,
	input  wire logic               noVideo,
	input  wire logic               holdOver,
	output logic                    hsyncOut,
	output logic                    vsyncOut,
	output logic                    activeVideoIn
);
	int p;
	int n;
	int ld;
	int len;
	int sp;
	logic isVid;
	// Every other video line is longer, so a minimum must really be tracked.
	always @(posedge clk) begin
		sp = ((n + 1) % 2) * 4;
		ld = int'(lead) + sp;
		len = 12 + ld + int'(trail) + sp;
		isVid = n == topLines + 2 || n == topLines + 3;
		if (!run) begin
			p <= 0;
			n <= 0;
			hsyncOut <= 1'b0;
			vsyncOut <= 1'b0;
			activeVideoIn <= 1'b0;
		end else begin
			hsyncOut <= p < 4;
			vsyncOut <= (n == 0 && p >= 4) || n == 1 || (n == 2 && p < 4);
			activeVideoIn <= !noVideo && ((isVid && p >= 4 + ld && p < 12 + ld)
				|| (holdOver && n == topLines + 4 && p < 2));
			p <= (p >= len - 1) ? 0 : p + 1;
			if (p >= len - 1) begin
				n <= (n >= 3 + topLines + botLines) ? 0 : n + 1;
			end
		end
	end
endmodule

/* sim/vtm_timing_measure_unit_test.sv */
`timescale 1ns/1ps
module vtm_timing_measure_unit_test;
	import vtm_pkg::*;
	logic              clk;
	logic              rst_n;
	logic [ADDR_W-1:0] regAddr;
	logic [DATA_W-1:0] regWrData;
	logic [DATA_W-1:0] regRdData;
	logic              regWr;
	logic              regRd;
	logic              hsyncOut;
	logic              vsyncOut;
	logic              activeVideoIn;
	logic              measureBusy;
	logic              run;
	logic              noVideo;
	logic              holdOver;
	logic signed [12:0] lead;
	logic [12:0]       trail;
	int                err_count;
	int                samples_checked;
	int                cycles;
	vtm_timing_measure_unit vtm_timing_measure_unit_inst (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .hsyncOut(hsyncOut),
		.vsyncOut(vsyncOut), .activeVideoIn(activeVideoIn), .measureBusy(measureBusy));
	vtm_video_source vtm_video_source_inst (.clk(clk), .run(run), .lead(lead), .trail(trail),
		.topLines(4'h3), .botLines(4'h1), .noVideo(noVideo), .holdOver(holdOver),
		.hsyncOut(hsyncOut), .vsyncOut(vsyncOut), .activeVideoIn(activeVideoIn));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			err_count++;
			final_report();
		end
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic final_report();
		$display("Checks %0d, errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Each access starts on a fresh edge, so strobes never get two drivers in one step.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1 d = regRdData;
	endtask
	////////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		logic [7:0] d;
		rd(OFF_CTRL_STATUS, d);
		chk("status reset", {3'h0, RST_CTRL_STATUS}, {3'h0, d});
		rd(OFF_TRAIL_LOW, d);
		chk("trail reset", {3'h0, RST_LOW}, {3'h0, d});
		wr(OFF_CTRL_STATUS, 8'h02);
		rd(OFF_CTRL_STATUS, d);
		chk("status write", 11'h0FE, {3'h0, d});
		wr(OFF_LEAD_LOW, 8'h00);
		rd(OFF_LEAD_LOW, d);
		chk("lead low write", {3'h0, RST_LOW}, {3'h0, d});
		rd(8'h3A, d);
		chk("unmapped", {3'h0, READ_UNMAPPED}, {3'h0, d});
	endtask
	task automatic measure(input logic ax, input int ld, input int tr, input logic nv, input logic ho,
		input logic [10:0] expLead, input logic [10:0] expTrail);
		logic [7:0] c;
		logic [7:0] lo;
		logic [7:0] hi;
		int k;
		lead <= 13'(ld);
		trail <= 13'(tr);
		noVideo <= nv;
		holdOver <= ho;
		run <= 1'b1;
		wr(OFF_CTRL_STATUS, {6'h00, ax, 1'b1});
		wr(OFF_CTRL_STATUS, {6'h00, !ax, 1'b0});
		rd(OFF_CTRL_STATUS, c);
		chk("busy axis start", {9'h000, ax, 1'b1}, {9'h000, c[1:0]});
		k = 0;
		while (measureBusy !== 1'b0 && k < 50000) begin
			@(posedge clk);
			k++;
		end
		if (k >= 50000) begin
			err_count++;
			final_report();
		end
		run <= 1'b0;
		rd(OFF_CTRL_STATUS, c);
		rd(OFF_LEAD_LOW, lo);
		rd(OFF_TRAIL_LOW, hi);
		chk("done axis start", {9'h000, ax, 1'b0}, {9'h000, c[1:0]});
		chk("lead", expLead, {c[4:2], lo});
		chk("trail", expTrail, {c[7:5], hi});
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		rst_n = 1'b0;
		regAddr = 8'h00;
		regWrData = 8'h00;
		regWr = 1'b0;
		regRd = 1'b0;
		run = 1'b0;
		noVideo = 1'b0;
		holdOver = 1'b0;
		lead = 13'h0000;
		trail = 13'h0000;
		cycles = 0;
		err_count = 0;
		samples_checked = 0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		measure(1'b1, 6, 5, 1'b0, 1'b0, 11'h006, 11'h005);
		measure(1'b0, 6, 5, 1'b0, 1'b0, 11'h003, 11'h002);
		measure(1'b1, 6, 5, 1'b1, 1'b0, CNT_MAX, CNT_MAX);
		measure(1'b1, -1, 5, 1'b0, 1'b1, LEAD_NEG_VAL, TRAIL_NEG_VAL);
		measure(1'b1, 2100, 5, 1'b0, 1'b0, CNT_MAX, 11'h005);
		final_report();
	end
endmodule
